/* shared/sls_pkg.sv */
/*
 * Shared constants and types for the status LED and strap pin block:
 * register numbers, field positions, reset levels and timing counts.
 * Assumes a single 20 MHz core clock and a 5-bit management register
 * number on the register port.
 */
package sls_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
   // strap window after reset release, least time, rounded up
   localparam int STRAP_TIME_NS = 400;
   localparam int STRAP_CYCLES  = (STRAP_TIME_NS * CLK_PER_US + 999) / 1000;
   // half period of the activity blink
   localparam int BLINK_TIME_US = 50_000;
   localparam int BLINK_CYCLES  = BLINK_TIME_US * CLK_PER_US;

   ////////////////////////////////////////////////////////////////////////
   // register port
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] REG_STRAP  = 5'h1B;
   localparam logic [ADDR_W-1:0] REG_PHYCTL = 5'h1F;

   // control register fields
   localparam int CTRL_SPEED_BIT  = 13;
   localparam int CTRL_ANEG_BIT   = 12;
   localparam int CTRL_DUPLEX_BIT = 8;
   // phy control register fields
   localparam int PHYCTL_INTPOL_BIT = 9;
   // strap status register fields
   localparam int STRAP_ADDR0_BIT = 0;
   localparam int STRAP_TEST_BIT  = 1;
   localparam int STRAP_DONE_BIT  = 2;
   localparam int STRAP_LINK_BIT  = 3;

   ////////////////////////////////////////////////////////////////////////
   // shared pins
   localparam int NUM_PINS   = 5;
   localparam int PIN_INT    = 0;
   localparam int PIN_LINK   = 1;
   localparam int PIN_SPEED  = 2;
   localparam int PIN_DUPLEX = 3;
   localparam int PIN_COL    = 4;
   // all pins carry internal pull-ups
   localparam logic [NUM_PINS-1:0] PIN_PULL_LEVEL = 5'h1F;
   // interrupt active low after reset
   localparam logic INTPOL_RESET = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic linkUp;
      logic activity;
      logic speed100;
      logic fullDuplex;
      logic collision;
   } sls_status_t;

   typedef struct packed {
      logic addrBit0;
      logic testMode;
      logic speed;
      logic duplex;
      logic autoneg;
   } sls_strap_t;

   typedef enum logic { ST_STRAP, ST_RUN } sls_phase_t;

endpackage : sls_pkg

/* design/sls_pin_sync.sv */
/*
 * Three-stage pin synchroniser with an agreement filter.
 * Assumes pins are asynchronous to clk; the held level moves only when
 * the second and third stages agree.
 */
`timescale 1ns/1ps

module sls_pin_sync #(
   parameter int                  W   = 1,
   parameter logic [W-1:0]        RST = '0
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // pins and filtered level
   input  wire logic [W-1:0]  pinIn,
   output logic      [W-1:0]  level
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   ////////////////////////////////////////////////////////////////////////
   // capture chain; stage1 feeds stage2 only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= RST;
         stage2 <= RST;
         stage3 <= RST;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // per-bit agreement filter rejects a single-cycle glitch
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_filt
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               level[i] <= RST[i];
            end else if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i];
            end
         end
      end
   endgenerate

endmodule : sls_pin_sync

/* design/sls_top.sv */
/*
 * Shared status pins: interrupt and four LEDs, each sampled as a strap
 * in a short window after reset release, then driven as an output.
 * Assumes board pull resistors settle before reset release, status
 * inputs come from logic on clk, and a register port with 5-bit address.
 */
`timescale 1ns/1ps

// Functional notes
// - interrupt pin polarity follows register 1f bit 9
// - interrupt pin strap becomes address bit 0
// - speed LED strap latched into control speed bit
// - speed LED low at 100, high at 10
// - duplex LED strap latched into control bit 8
// - collision LED strap latched into control bit 12
// - collision pin becomes collision output after strapping
module sls_top #(
   parameter int STRAP_CYCLES = sls_pkg::STRAP_CYCLES,
   parameter int BLINK_CYCLES = sls_pkg::BLINK_CYCLES
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // register port
   input  wire logic [sls_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [sls_pkg::DATA_W-1:0]  regWdata,
   input  wire logic                        regWrite,
   input  wire logic                        regRead,
   output logic      [sls_pkg::DATA_W-1:0]  regRdata,
   // core status
   input  wire sls_pkg::sls_status_t        linkStatus,
   input  wire logic                        irqReq,
   // interrupt / address strap pin
   input  wire logic                        intPinIn,
   output logic                             intPinOut,
   output logic                             intPinOe,
   // link and activity LED pin
   input  wire logic                        linkActivityLedIn,
   output logic                             linkActivityLedOut,
   output logic                             linkActivityLedOe,
   // speed LED pin
   input  wire logic                        speedLedIn,
   output logic                             speedLedOut,
   output logic                             speedLedOe,
   // duplex LED pin
   input  wire logic                        duplexLedIn,
   output logic                             duplexLedOut,
   output logic                             duplexLedOe,
   // collision LED pin
   input  wire logic                        collisionLedIn,
   output logic                             collisionLedOut,
   output logic                             collisionLedOe,
   // latched configuration
   output logic                             phyAddrBit0Strap,
   output logic                             testModeStrap,
   output logic                             speedSelect,
   output logic                             duplexMode,
   output logic                             autonegEnableBit,
   output logic                             strapDone
);

   localparam int SW = $clog2(STRAP_CYCLES + 1);
   localparam int BW = $clog2(BLINK_CYCLES + 1);

   sls_pkg::sls_phase_t          phase;
   logic [SW-1:0]                strapCnt;
   logic [BW-1:0]                blinkCnt;
   logic                         blinkPhase;
   logic                         intPol;
   logic                         strapEnd;
   logic [sls_pkg::NUM_PINS-1:0] pinRaw;
   logic [sls_pkg::NUM_PINS-1:0] pinLevel;
   sls_pkg::sls_strap_t          strapNow;

   ////////////////////////////////////////////////////////////////////////
   // pin sampling
   assign pinRaw[sls_pkg::PIN_INT]    = intPinIn;
   assign pinRaw[sls_pkg::PIN_LINK]   = linkActivityLedIn;
   assign pinRaw[sls_pkg::PIN_SPEED]  = speedLedIn;
   assign pinRaw[sls_pkg::PIN_DUPLEX] = duplexLedIn;
   assign pinRaw[sls_pkg::PIN_COL]    = collisionLedIn;

   sls_pin_sync #(
      .W   (sls_pkg::NUM_PINS),
      .RST (sls_pkg::PIN_PULL_LEVEL)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pinIn (pinRaw),
      .level (pinLevel)
   );

   // strap view of the filtered pins
   assign strapNow.addrBit0 = pinLevel[sls_pkg::PIN_INT];
   assign strapNow.testMode = ~pinLevel[sls_pkg::PIN_LINK];
   assign strapNow.speed    = pinLevel[sls_pkg::PIN_SPEED];
   assign strapNow.duplex   = pinLevel[sls_pkg::PIN_DUPLEX];
   assign strapNow.autoneg  = pinLevel[sls_pkg::PIN_COL];

   ////////////////////////////////////////////////////////////////////////
   // strap window: pins float for STRAP_CYCLES after release, since a
   // reset flop may not capture a pin; covers the synchroniser depth
   assign strapEnd = (phase == sls_pkg::ST_STRAP) &&
                     (strapCnt == SW'(STRAP_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase    <= sls_pkg::ST_STRAP;
         strapCnt <= '0;
      end else if (strapEnd) begin
         phase    <= sls_pkg::ST_RUN;
      end else if (phase == sls_pkg::ST_STRAP) begin
         strapCnt <= strapCnt + SW'(1);
      end
   end

   // strap-only results
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phyAddrBit0Strap <= 1'b0;
         testModeStrap    <= 1'b0;
         strapDone        <= 1'b0;
      end else if (strapEnd) begin
         phyAddrBit0Strap <= strapNow.addrBit0;
         testModeStrap    <= strapNow.testMode;
         strapDone        <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register 0; strap load wins over a write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speedSelect      <= 1'b0;
         duplexMode       <= 1'b0;
         autonegEnableBit <= 1'b0;
      end else if (strapEnd) begin
         speedSelect      <= strapNow.speed;
         duplexMode       <= strapNow.duplex;
         autonegEnableBit <= strapNow.autoneg;
      end else if (regWrite && regAddr == sls_pkg::REG_CTRL) begin
         speedSelect      <= regWdata[sls_pkg::CTRL_SPEED_BIT];
         duplexMode       <= regWdata[sls_pkg::CTRL_DUPLEX_BIT];
         autonegEnableBit <= regWdata[sls_pkg::CTRL_ANEG_BIT];
      end
   end

   // interrupt polarity, register 1f
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intPol <= sls_pkg::INTPOL_RESET;
      end else if (regWrite && regAddr == sls_pkg::REG_PHYCTL) begin
         intPol <= regWdata[sls_pkg::PHYCTL_INTPOL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped numbers read zero
   function automatic logic [sls_pkg::DATA_W-1:0] readMux(
      input logic [sls_pkg::ADDR_W-1:0] addr
   );
      logic [sls_pkg::DATA_W-1:0] d;
      d = '0;
      if (addr == sls_pkg::REG_CTRL) begin
         d[sls_pkg::CTRL_SPEED_BIT]  = speedSelect;
         d[sls_pkg::CTRL_DUPLEX_BIT] = duplexMode;
         d[sls_pkg::CTRL_ANEG_BIT]   = autonegEnableBit;
      end else if (addr == sls_pkg::REG_PHYCTL) begin
         d[sls_pkg::PHYCTL_INTPOL_BIT] = intPol;
      end else if (addr == sls_pkg::REG_STRAP) begin
         d[sls_pkg::STRAP_ADDR0_BIT] = phyAddrBit0Strap;
         d[sls_pkg::STRAP_TEST_BIT]  = testModeStrap;
         d[sls_pkg::STRAP_DONE_BIT]  = strapDone;
         d[sls_pkg::STRAP_LINK_BIT]  = linkStatus.linkUp;
      end
      return d;
   endfunction : readMux

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= '0;
      end else if (regRead) begin
         regRdata <= readMux(regAddr);
      end else begin
         regRdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // activity blink; counter idles without traffic to save toggling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blinkCnt   <= '0;
         blinkPhase <= 1'b0;
      end else if (!(linkStatus.linkUp && linkStatus.activity)) begin
         blinkCnt   <= '0;
         blinkPhase <= 1'b0;
      end else if (blinkCnt == BW'(BLINK_CYCLES - 1)) begin
         blinkCnt   <= '0;
         blinkPhase <= ~blinkPhase;
      end else begin
         blinkCnt   <= blinkCnt + BW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers: released during reset and strap window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intPinOut          <= 1'b1;
         intPinOe           <= 1'b0;
         linkActivityLedOut <= 1'b1;
         linkActivityLedOe  <= 1'b0;
         speedLedOut        <= 1'b1;
         speedLedOe         <= 1'b0;
         duplexLedOut       <= 1'b1;
         duplexLedOe        <= 1'b0;
         collisionLedOut    <= 1'b1;
         collisionLedOe     <= 1'b0;
      end else if (phase == sls_pkg::ST_RUN) begin
         intPinOut          <= irqReq ? intPol : ~intPol;
         intPinOe           <= 1'b1;
         linkActivityLedOut <= ~linkStatus.linkUp | blinkPhase;
         linkActivityLedOe  <= 1'b1;
         speedLedOut        <= ~linkStatus.speed100;
         speedLedOe         <= 1'b1;
         duplexLedOut       <= ~linkStatus.fullDuplex;
         duplexLedOe        <= 1'b1;
         collisionLedOut    <= ~linkStatus.collision;
         collisionLedOe     <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_strap_pins_off: assert property (
      phase == sls_pkg::ST_STRAP |->
         !(intPinOe | linkActivityLedOe | speedLedOe | duplexLedOe |
           collisionLedOe))
      else $error("pin driven during strap window");

   a_int_pol: assert property (
      $past(phase) == sls_pkg::ST_RUN |->
         intPinOe && intPinOut == ($past(irqReq) ? $past(intPol)
                                                 : !$past(intPol)))
      else $error("interrupt pin level wrong for polarity");

   a_addr_latch: assert property (
      strapEnd |=> phyAddrBit0Strap == $past(pinLevel[sls_pkg::PIN_INT])
                   && strapDone)
      else $error("address bit 0 strap not latched");

   a_test_latch: assert property (
      strapEnd |=> testModeStrap == !$past(pinLevel[sls_pkg::PIN_LINK]))
      else $error("test strap not latched");

   a_speed_latch: assert property (
      strapEnd |=> speedSelect == $past(pinLevel[sls_pkg::PIN_SPEED]))
      else $error("speed strap not latched");

   a_duplex_latch: assert property (
      strapEnd |=> duplexMode == $past(pinLevel[sls_pkg::PIN_DUPLEX]))
      else $error("duplex strap not latched");

   a_aneg_latch: assert property (
      strapEnd |=> autonegEnableBit == $past(pinLevel[sls_pkg::PIN_COL]))
      else $error("autoneg strap not latched");

   a_speed_led: assert property (
      $past(phase) == sls_pkg::ST_RUN |->
         speedLedOe && speedLedOut == !$past(linkStatus.speed100))
      else $error("speed LED level wrong");

   a_duplex_led: assert property (
      $past(phase) == sls_pkg::ST_RUN |->
         duplexLedOut == !$past(linkStatus.fullDuplex))
      else $error("duplex LED level wrong");

   a_col_led: assert property (
      $past(phase) == sls_pkg::ST_RUN |->
         collisionLedOe && collisionLedOut == !$past(linkStatus.collision))
      else $error("collision LED level wrong");

   a_link_led: assert property (
      ($past(phase) == sls_pkg::ST_RUN && !$past(linkStatus.linkUp)) |->
         linkActivityLedOut)
      else $error("link LED lit without link");

   a_link_idle: assert property (
      ($past(phase) == sls_pkg::ST_RUN && $past(linkStatus.linkUp) &&
       !$past(linkStatus.activity, 2) && !$past(linkStatus.activity)) |->
         !linkActivityLedOut)
      else $error("link LED dark with idle link");

   c_strap_end:  cover property (strapEnd);
   c_blink:      cover property ($rose(blinkPhase));
   c_pol_change: cover property ($changed(intPol) && irqReq);

endmodule : sls_top

/* verif/sls_board.sv */
/*
 * Board side of the shared status pins: the pull resistors that set each
 * strap level, and the wire level that the block's pin inputs see.
 * Assumes push-pull drive from the block while its enable is high.
 */
`timescale 1ns/1ps

module sls_board (
   // strap resistor level per pin, in package pin order
   input  wire logic [sls_pkg::NUM_PINS-1:0] pullLevel,
   // block drive
   input  wire logic [sls_pkg::NUM_PINS-1:0] pinOut,
   input  wire logic [sls_pkg::NUM_PINS-1:0] pinOe,
   // resolved wire level
   output logic      [sls_pkg::NUM_PINS-1:0] pinLevel
);
   ////////////////////////////////////////////////////////////////////////
   // undriven pin rests on its resistor, never on a stale drive value;
   // the link pin stays pulled high unless a test strap is commanded
   always_comb begin
      for (int i = 0; i < sls_pkg::NUM_PINS; i++) begin
         pinLevel[i] = pinOe[i] ? pinOut[i] : pullLevel[i];
      end
   end
endmodule : sls_board

/* verif/sls_top_tb_top.sv */
/*
 * Self-checking bench for the status LED and strap pin block.
 * Assumes the board model in sls_board and the register port timing of
 * the block: read data in the cycle after the read strobe only.
 */
`timescale 1ns/1ps

module sls_top_tb_top;
   localparam int STRAP_N = 8;
   localparam int BLINK_N = 4;
   localparam int LIMIT   = 3000;

   logic                  clk        = 1'b0;
   logic                  rst_n      = 1'b0;
   logic [4:0]            regAddr    = 5'h00;
   logic [15:0]           regWdata   = 16'h0000;
   logic                  regWrite   = 1'b0;
   logic                  regRead    = 1'b0;
   logic [15:0]           regRdata;
   sls_pkg::sls_status_t  linkStatus = '0;
   logic                  irqReq     = 1'b0;
   logic [4:0]            pull       = 5'h1F;
   logic [4:0]            pinOut;
   logic [4:0]            pinOe;
   logic [4:0]            pinLevel;
   logic                  phyAddrBit0Strap;
   logic                  testModeStrap;
   logic                  speedSelect;
   logic                  duplexMode;
   logic                  autonegEnableBit;
   logic                  strapDone;
   int                    err_total  = 0;
   int                    compares   = 0;
   int                    cycles     = 0;
   logic [4:0]            pats [3]   = '{5'h1F, 5'h15, 5'h0A};

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // block and board
   sls_top #(.STRAP_CYCLES(STRAP_N), .BLINK_CYCLES(BLINK_N)) dut (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .linkStatus(linkStatus), .irqReq(irqReq),
      .intPinIn(pinLevel[0]), .intPinOut(pinOut[0]), .intPinOe(pinOe[0]),
      .linkActivityLedIn(pinLevel[1]), .linkActivityLedOut(pinOut[1]),
      .linkActivityLedOe(pinOe[1]),
      .speedLedIn(pinLevel[2]), .speedLedOut(pinOut[2]),
      .speedLedOe(pinOe[2]),
      .duplexLedIn(pinLevel[3]), .duplexLedOut(pinOut[3]),
      .duplexLedOe(pinOe[3]),
      .collisionLedIn(pinLevel[4]), .collisionLedOut(pinOut[4]),
      .collisionLedOe(pinOe[4]),
      .phyAddrBit0Strap(phyAddrBit0Strap), .testModeStrap(testModeStrap),
      .speedSelect(speedSelect), .duplexMode(duplexMode),
      .autonegEnableBit(autonegEnableBit), .strapDone(strapDone));

   sls_board board (.pullLevel(pull), .pinOut(pinOut), .pinOe(pinOe),
      .pinLevel(pinLevel));

   ////////////////////////////////////////////////////////////////////////
   // compare, verdict and hang guard
   function automatic logic [15:0] w(input logic b);
      return {15'h0000, b};
   endfunction : w

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port and pin tasks
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rd_check(input logic [4:0] a, input logic [15:0] exp,
                           input string name);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      check(name, regRdata, exp);
   endtask : rd_check

   // status changes land on the pins at the edge that samples them; the blink path lags one more edge
   task automatic set_status(input sls_pkg::sls_status_t s, input logic i);
      @(posedge clk);
      linkStatus <= s;
      irqReq <= i;
      repeat (2) @(posedge clk);
      #1;
   endtask : set_status

   // straps must be stable before release and through the whole window
   task automatic do_reset(input logic [4:0] p);
      @(posedge clk);
      pull <= p;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      check("oe in reset", {11'h000, pinOe}, 16'h0000);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("oe in window", {11'h000, pinOe}, 16'h0000);
      repeat (STRAP_N) @(posedge clk);
      #1;
   endtask : do_reset

   task automatic watch_link(output logic [1:0] seen);
      seen = 2'b00;
      repeat (3 * BLINK_N) begin
         @(posedge clk);
         #1;
         if (pinOut[1] === 1'b1) seen[1] = 1'b1;
         if (pinOut[1] === 1'b0) seen[0] = 1'b1;
      end
   endtask : watch_link

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [4:0]           p;
      logic [1:0]           seen;
      sls_pkg::sls_status_t st;
      // straps, with a reset before each pattern, the later two in mid-run
      for (int k = 0; k < 3; k++) begin
         p = pats[k];
         do_reset(p);
         check("addr0 strap", w(phyAddrBit0Strap), w(p[0]));
         check("test strap", w(testModeStrap), w(!p[1]));
         check("speed strap", w(speedSelect), w(p[2]));
         check("duplex strap", w(duplexMode), w(p[3]));
         check("aneg strap", w(autonegEnableBit), w(p[4]));
         check("strap done", w(strapDone), w(1'b1));
         rd_check(5'h00, {2'b00, p[2], p[4], 3'b000, p[3], 8'h00},
                  "ctrl reg");
         rd_check(5'h1B, {12'h000, 1'b0, 1'b1, !p[1], p[0]},
                  "strap reg");
         check("oe after window", {11'h000, pinOe}, 16'h001F);
      end
      // control bits writable; reserved bits and unmapped place read 0
      wr(5'h00, 16'hFFFF);
      rd_check(5'h00, 16'h3100, "ctrl all ones");
      check("aneg bit", w(autonegEnableBit), w(1'b1));
      wr(5'h00, 16'h0000);
      rd_check(5'h00, 16'h0000, "ctrl zero");
      wr(5'h05, 16'hFFFF);
      rd_check(5'h05, 16'h0000, "unmapped");
      // interrupt polarity against both request levels
      for (int pol = 0; pol < 2; pol++) begin
         wr(5'h1F, pol[0] ? 16'hFFFF : 16'h0000);
         rd_check(5'h1F, pol[0] ? 16'h0200 : 16'h0000, "pol reg");
         for (int q = 0; q < 2; q++) begin
            set_status('0, q[0]);
            check("int pin", w(pinOut[0]),
                  w(q[0] ? pol[0] : !pol[0]));
         end
      end
      // speed, duplex and collision lamps are all active low
      for (int s = 0; s < 2; s++) begin
         st = '0;
         st.speed100 = s[0];
         st.fullDuplex = s[0];
         st.collision = s[0];
         set_status(st, 1'b0);
         check("speed led", w(pinOut[2]), w(!s[0]));
         check("duplex led", w(pinOut[3]), w(!s[0]));
         check("col led", w(pinOut[4]), w(!s[0]));
      end
      // link lamp: off, steady on, then blinking with traffic
      st = '0;
      set_status(st, 1'b0);
      check("link off", w(pinOut[1]), w(1'b1));
      st.linkUp = 1'b1;
      set_status(st, 1'b0);
      // last straps were 5'h0A: address 0, no test, done, link up
      rd_check(5'h1B, 16'h000C, "strap link");
      watch_link(seen);
      check("link steady", {14'h0000, seen}, 16'h0001);
      st.activity = 1'b1;
      set_status(st, 1'b0);
      watch_link(seen);
      check("link blink", {14'h0000, seen}, 16'h0003);
      results();
   end
endmodule : sls_top_tb_top
